// File: hw/mrpc_top.sv
// Summary of operation
// - command port is synchronous, full duplex, bit-serial, one byte per command.
// - command link has select, clock, data in, data out, interrupt.
// - count selector picks one (none at address 15), two (one at block 14), four (three at 12-14) or all outputs.
// - level selector picks bias, offset or reset level.
// - 4-bit group address names the selected outputs.
// - strobe rising edge floats the selected outputs first.
// - after break-before-make delay, selected outputs latch chosen level.
// - outputs hold last latched level until the next pulse step.
// - array is 15 blocks of 72 rows each.
// - first and last 64 pixel bits per row are not visible.
// - four grouping modes decide which blocks get a pulse.
// - single mode pulses any one block, any order.
// - dual mode pairs 0-1 up to 12-13, block 14 alone.
// - quad mode groups 0-3, 4-7, 8-11, 12-14.
`timescale 1ns/1ps
module mrpc_top (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic cmd_port_clock_i,
	input wire logic cmd_port_select_n_i,
	input wire logic cmd_port_data_in_i,
	output logic cmd_port_data_out_o,
	output logic cmd_port_data_out_oe_n_o,
	output logic cmd_port_irq_o,
	input wire logic strobe_i,
	input wire logic [1:0] count_mode_i,
	input wire logic [1:0] level_sel_i,
	input wire logic [3:0] group_addr_i,
	output logic [2*mrpc_pkg::NUM_BLOCKS-1:0] mirror_pulse_lines_level_o,
	output logic [mrpc_pkg::NUM_BLOCKS-1:0] mirror_pulse_lines_oe_n_o,
	output logic pulse_busy_o
);
	localparam int NB = mrpc_pkg::NUM_BLOCKS;

	// blocks selected by count mode and group address
	function automatic logic [NB-1:0] group_mask(
		input logic [1:0] mode,
		input logic [3:0] addr
	);
		logic [15:0] m;
		m = 16'h0000;
		case (mode)
			mrpc_pkg::CNT_SINGLE: begin
				m = 16'h0001 << addr;
			end
			mrpc_pkg::CNT_DUAL: begin
				m = 16'h0003 << {addr[3:1], 1'b0};
			end
			mrpc_pkg::CNT_QUAD: begin
				m = 16'h000F << {addr[3:2], 2'b00};
			end
			default: begin
				m = 16'hFFFF;
			end
		endcase
		return m[NB-1:0];
	endfunction

	mrpc_link_if link ();

	mrpc_cmd_port u_cmd_port (
		.nrst_i(nrst_i),
		.cmd_port_clock_i(cmd_port_clock_i),
		.cmd_port_select_n_i(cmd_port_select_n_i),
		.cmd_port_data_in_i(cmd_port_data_in_i),
		.cmd_port_data_out_o(cmd_port_data_out_o),
		.cmd_port_data_out_oe_n_o(cmd_port_data_out_oe_n_o),
		.link(link.port)
	);

	logic [8:0] ctrl_s1_q;
	logic [8:0] ctrl_s2_q;
	logic strobe_s3_q;
	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic busy_q;
	logic [mrpc_pkg::BBM_CNT_W-1:0] bbm_cnt_q;
	logic [NB-1:0] mask_q;
	logic [1:0] pend_level_q;
	logic [NB-1:0][1:0] level_q;
	logic [NB-1:0] hiz_q;
	logic en_q;
	logic irq_q;
	logic sel_s1_q;
	logic sel_s2_q;
	logic [mrpc_pkg::ST_W-1:0] st_hold_q;

	logic strobe_s2;
	logic [1:0] c_mode;
	logic [1:0] c_level;
	logic [3:0] c_addr;
	logic strobe_rise;
	logic level_ok;
	logic accept;
	logic bbm_done;
	logic rx_pulse;
	logic [NB-1:0] sel_mask;

	assign strobe_s2 = ctrl_s2_q[8];
	assign c_mode = ctrl_s2_q[7:6];
	assign c_level = ctrl_s2_q[5:4];
	assign c_addr = ctrl_s2_q[3:0];
	assign strobe_rise = strobe_s2 && !strobe_s3_q;
	assign level_ok = (c_level != mrpc_pkg::LVL_INVALID);
	assign accept = strobe_rise && !busy_q && level_ok;
	assign bbm_done = busy_q && (bbm_cnt_q == '0);
	assign rx_pulse = tgl_s2_q ^ tgl_s3_q;
	assign sel_mask = group_mask(c_mode, c_addr);

	// pin inputs and the link toggle pass two flip-flops
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			ctrl_s1_q <= 9'h000;
			ctrl_s2_q <= 9'h000;
			strobe_s3_q <= 1'b0;
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else if (ce_i) begin
			ctrl_s1_q <= {strobe_i, count_mode_i, level_sel_i, group_addr_i};
			ctrl_s2_q <= ctrl_s1_q;
			strobe_s3_q <= strobe_s2;
			tgl_s1_q <= link.rx_toggle;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	// break-before-make sequencer
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			busy_q <= 1'b0;
			bbm_cnt_q <= '0;
			mask_q <= '0;
			pend_level_q <= mrpc_pkg::LEVEL_RESET;
		end else if (ce_i) begin
			if (accept) begin
				busy_q <= 1'b1;
				bbm_cnt_q <= mrpc_pkg::BBM_CNT_W'(mrpc_pkg::BBM_CYC - 1);
				mask_q <= sel_mask;
				pend_level_q <= c_level;
			end else if (bbm_done) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				bbm_cnt_q <= bbm_cnt_q - 1'b1;
			end
		end
	end

	// float on strobe, latch after delay, hold otherwise
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			hiz_q <= '0;
			level_q <= '0;
		end else if (ce_i) begin
			if (accept) begin
				hiz_q <= hiz_q | sel_mask;
			end else if (bbm_done) begin
				for (int i = 0; i < NB; i++) begin
					if (mask_q[i]) begin
						level_q[i] <= pend_level_q;
						hiz_q[i] <= 1'b0;
					end
				end
			end
		end
	end

	// serial commands: output enable and float
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			en_q <= mrpc_pkg::EN_RESET;
		end else if (ce_i && rx_pulse) begin
			if (link.rx_byte == mrpc_pkg::CMD_ENABLE) begin
				en_q <= 1'b1;
			end else if (link.rx_byte == mrpc_pkg::CMD_FLOAT) begin
				en_q <= 1'b0;
			end
		end
	end

	// misuse flag; a new event wins over the clear
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			irq_q <= 1'b0;
		end else if (ce_i) begin
			if ((strobe_rise && busy_q) || (strobe_rise && !level_ok)) begin
				irq_q <= 1'b1;
			end else if (rx_pulse && link.rx_byte == mrpc_pkg::CMD_CLEAR_IRQ) begin
				irq_q <= 1'b0;
			end
		end
	end

	// status snapshot, frozen while the link is selected
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			st_hold_q <= '0;
		end else if (ce_i) begin
			sel_s1_q <= cmd_port_select_n_i;
			sel_s2_q <= sel_s1_q;
			if (sel_s2_q) begin
				st_hold_q[mrpc_pkg::ST_IRQ_BIT] <= irq_q;
				st_hold_q[mrpc_pkg::ST_BUSY_BIT] <= busy_q;
				st_hold_q[mrpc_pkg::ST_EN_BIT] <= en_q;
			end
		end
	end

	assign link.status = st_hold_q;
	assign cmd_port_irq_o = irq_q;
	assign pulse_busy_o = busy_q;
	assign mirror_pulse_lines_level_o = level_q;
	assign mirror_pulse_lines_oe_n_o = hiz_q | {NB{~en_q}};

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i || !ce_i);

	chk_float_on_strobe: assert property (
		accept |=> ((hiz_q & $past(sel_mask)) == $past(sel_mask)))
		else $error("selected lines not floated after strobe");

	chk_bbm_interval: assert property (
		accept |=> busy_q [*5] ##1 !busy_q)
		else $error("break-before-make interval wrong");

	chk_level_latch: assert property (
		$fell(busy_q) |-> ((hiz_q & $past(mask_q)) == '0))
		else $error("selected lines not driven after delay");

	chk_level_hold: assert property (
		(!busy_q && !accept) |=> $stable(level_q))
		else $error("levels changed outside a pulse step");

	chk_irq_on_busy: assert property (
		(strobe_rise && busy_q) |=> irq_q)
		else $error("strobe during delay not flagged");

	chk_global_all: assert property (
		(accept && c_mode == mrpc_pkg::CNT_GLOBAL) |=> (mask_q == '1))
		else $error("global mode missed blocks");

	chk_single_one: assert property (
		(accept && c_mode == mrpc_pkg::CNT_SINGLE && c_addr != 4'hF)
		|-> ($countones(sel_mask) == 1 && sel_mask[c_addr]))
		else $error("single mode selection wrong");

	chk_dual_pair: assert property (
		(accept && c_mode == mrpc_pkg::CNT_DUAL) |->
		($countones(sel_mask) == ((c_addr[3:1] == 3'h7) ? 1 : 2)))
		else $error("dual mode pairing wrong");

	chk_quad_group: assert property (
		(accept && c_mode == mrpc_pkg::CNT_QUAD) |->
		($countones(sel_mask) == ((c_addr[3:2] == 2'h3) ? 3 : 4)))
		else $error("quad mode grouping wrong");

	chk_float_cmd: assert property (
		(rx_pulse && link.rx_byte == mrpc_pkg::CMD_FLOAT) |=>
		(mirror_pulse_lines_oe_n_o == '1))
		else $error("float command ignored");

	chk_irq_on_level: assert property (
		(strobe_rise && !level_ok) |=> irq_q)
		else $error("invalid level not flagged");

	chk_enable_cmd: assert property (
		(rx_pulse && link.rx_byte == mrpc_pkg::CMD_ENABLE) |=> en_q)
		else $error("enable command ignored");

	chk_irq_clear: assert property (
		(rx_pulse && link.rx_byte == mrpc_pkg::CMD_CLEAR_IRQ && !strobe_rise)
		|=> !irq_q)
		else $error("irq clear ignored");

	chk_status_frozen: assert property (
		!sel_s2_q |=> $stable(st_hold_q))
		else $error("status changed during a frame");

	chk_status_fresh: assert property (
		sel_s2_q |=> (st_hold_q[mrpc_pkg::ST_IRQ_BIT] == $past(irq_q)))
		else $error("status snapshot stale");

	chk_refuse_busy: assert property (
		(strobe_rise && busy_q) |=> $stable(mask_q))
		else $error("strobe during delay changed selection");
endmodule

// File: hw/mrpc_pkg.sv
package mrpc_pkg;
	// array partitioning
	localparam int NUM_BLOCKS = 15;
	localparam int ROWS_PER_BLOCK = 72;
	localparam int HIDDEN_PIXELS_PER_SIDE = 64;

	// output-count selector codes, kept configurable
	localparam logic [1:0] CNT_SINGLE = 2'h0;
	localparam logic [1:0] CNT_DUAL = 2'h1;
	localparam logic [1:0] CNT_QUAD = 2'h2;
	localparam logic [1:0] CNT_GLOBAL = 2'h3;

	// level selector codes, kept configurable
	localparam logic [1:0] LVL_BIAS = 2'h0;
	localparam logic [1:0] LVL_OFFSET = 2'h1;
	localparam logic [1:0] LVL_RESET = 2'h2;
	localparam logic [1:0] LVL_INVALID = 2'h3;

	// break-before-make interval
	localparam int CLK_PERIOD_NS = 40;
	localparam int BBM_NS = 200;
	localparam int BBM_CYC = (BBM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BBM_CNT_W = 3;

	// serial command bytes
	localparam int CMD_BITS = 8;
	localparam logic [7:0] CMD_CLEAR_IRQ = 8'h01;
	localparam logic [7:0] CMD_ENABLE = 8'h02;
	localparam logic [7:0] CMD_FLOAT = 8'h03;

	// status byte bit positions
	localparam int ST_IRQ_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_EN_BIT = 2;
	localparam int ST_W = 3;

	// reset values
	localparam logic EN_RESET = 1'b1;
	localparam logic [1:0] LEVEL_RESET = 2'h0;
endpackage

// File: hw/mrpc_link_if.sv
`timescale 1ns/1ps
interface mrpc_link_if;
	logic [7:0] rx_byte;
	logic rx_toggle;
	logic [mrpc_pkg::ST_W-1:0] status;
	modport port (output rx_byte, output rx_toggle, input status);
	modport core (input rx_byte, input rx_toggle, output status);
endinterface

// File: hw/mrpc_cmd_port.sv
`timescale 1ns/1ps
module mrpc_cmd_port (
	input wire logic nrst_i,
	input wire logic cmd_port_clock_i,
	input wire logic cmd_port_select_n_i,
	input wire logic cmd_port_data_in_i,
	output logic cmd_port_data_out_o,
	output logic cmd_port_data_out_oe_n_o,
	mrpc_link_if.port link
);
	logic [2:0] bit_cnt_q;
	logic [6:0] rx_sh_q;
	logic [7:0] rx_byte_q;
	logic rx_toggle_q;
	logic [6:0] tx_sh_q;
	logic [7:0] st_byte;

	// core holds this snapshot still while the port is selected
	assign st_byte = {5'h00, link.status};

	// bit counter restarts whenever the port is deselected
	always_ff @(posedge cmd_port_clock_i or posedge cmd_port_select_n_i) begin
		if (cmd_port_select_n_i) begin
			bit_cnt_q <= 3'h0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// whole bytes only, msb first
	always_ff @(posedge cmd_port_clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_sh_q <= 7'h00;
			rx_byte_q <= 8'h00;
			rx_toggle_q <= 1'b0;
			tx_sh_q <= 7'h00;
		end else if (!cmd_port_select_n_i) begin
			rx_sh_q <= {rx_sh_q[5:0], cmd_port_data_in_i};
			if (bit_cnt_q == 3'h7) begin
				rx_byte_q <= {rx_sh_q, cmd_port_data_in_i};
				rx_toggle_q <= ~rx_toggle_q;
			end
			if (bit_cnt_q == 3'h0) begin
				tx_sh_q <= st_byte[6:0];
			end else begin
				tx_sh_q <= {tx_sh_q[5:0], 1'b0};
			end
		end
	end

	// full duplex: status byte shifts out while a command shifts
	assign cmd_port_data_out_o = (bit_cnt_q == 3'h0) ? st_byte[7] : tx_sh_q[6];
	assign cmd_port_data_out_oe_n_o = cmd_port_select_n_i;
	assign link.rx_byte = rx_byte_q;
	assign link.rx_toggle = rx_toggle_q;
endmodule

// File: bench/mrpc_ctrl_model.sv
`timescale 1ns/1ps
module mrpc_ctrl_model (
	input wire logic core_clk_i,
	input wire logic sdo_i,
	output logic strobe_o,
	output logic [1:0] mode_o,
	output logic [1:0] lvl_o,
	output logic [3:0] addr_o,
	output logic sel_n_o,
	output logic sck_o,
	output logic sdi_o
);
	initial begin
		strobe_o = 1'b0;
		mode_o = 2'h0;
		lvl_o = 2'h0;
		addr_o = 4'h0;
		sel_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
	// group settles 3 cycles before the strobe rises
	// data assumed loaded before each step
	task automatic step(input logic [1:0] m, l, input logic [3:0] a);
		@(posedge core_clk_i);
		mode_o <= m;
		lvl_o <= l;
		addr_o <= a;
		repeat (3) @(posedge core_clk_i);
		strobe_o <= 1'b1;
	endtask
	task automatic drop();
		@(posedge core_clk_i);
		strobe_o <= 1'b0;
	endtask
	// link clock runs only inside a frame, 30 ns period
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		#7;
		sel_n_o = 1'b0;
		// let the core freeze its status snapshot first
		#120;
		for (int i = 7; i >= 0; i--) begin
			sdi_o = b[i];
			#15;
			r[i] = sdo_i;
			sck_o = 1'b1;
			#15;
			sck_o = 1'b0;
		end
		#15;
		sel_n_o = 1'b1;
		sdi_o = ~b[0];
	endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic strobe, sel_n, sck, sdi, sdo, sdo_oe_n, irq, busy;
	logic [1:0] mode, lvl;
	logic [3:0] addr;
	logic [29:0] levels, exp_lv;
	logic [14:0] oe_n;
	logic [7:0] rd;
	logic [1:0] lv_tab [3] = '{mrpc_pkg::LVL_BIAS, mrpc_pkg::LVL_OFFSET,
		mrpc_pkg::LVL_RESET};
	int fail_count = 0;
	int comparisons = 0;
	always #20 core_clk_i = ~core_clk_i;
	mrpc_top dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.cmd_port_clock_i(sck), .cmd_port_select_n_i(sel_n),
		.cmd_port_data_in_i(sdi), .cmd_port_data_out_o(sdo),
		.cmd_port_data_out_oe_n_o(sdo_oe_n), .cmd_port_irq_o(irq),
		.strobe_i(strobe), .count_mode_i(mode), .level_sel_i(lvl),
		.group_addr_i(addr), .mirror_pulse_lines_level_o(levels),
		.mirror_pulse_lines_oe_n_o(oe_n), .pulse_busy_o(busy));
	mrpc_ctrl_model ctl (.core_clk_i(core_clk_i), .sdo_i(sdo),
		.strobe_o(strobe), .mode_o(mode), .lvl_o(lvl), .addr_o(addr),
		.sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi));
	task automatic chk(input logic [31:0] got, exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			#1;
		end
	endtask
	function automatic logic [14:0] sel_mask(input logic [1:0] m,
		input logic [3:0] a);
		logic [14:0] w;
		w = '0;
		for (int i = 0; i < 15; i++) begin
			case (m)
				mrpc_pkg::CNT_SINGLE: w[i] = (i == a);
				mrpc_pkg::CNT_DUAL: w[i] = (i / 2 == a / 2);
				mrpc_pkg::CNT_QUAD: w[i] = (i / 4 == a / 4);
				default: w[i] = 1'b1;
			endcase
		end
		return w;
	endfunction
	task automatic step_chk(input logic [1:0] m, l, input logic [3:0] a);
		logic [14:0] mk;
		int n;
		mk = sel_mask(m, a);
		n = 0;
		ctl.step(m, l, a);
		tick(1);
		while (busy !== 1'b1 && n < 8) begin
			tick(1);
			n++;
		end
		if (n >= 8) begin
			fail_count++;
			summarize();
		end
		chk(oe_n & mk, mk, "float");
		n = 0;
		while (busy === 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		chk(n, mrpc_pkg::BBM_CYC, "bbm");
		for (int i = 0; i < 15; i++) begin
			if (mk[i]) begin
				exp_lv[2*i +: 2] = l;
			end
		end
		chk(levels, exp_lv, "levels");
		chk(oe_n, 15'h0, "drive");
		ctl.drop();
	endtask
	initial begin
		int seed;
		logic [1:0] m;
		logic [3:0] a;
		exp_lv = '0;
		seed = $urandom(32'hC5427397);
		repeat (20) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		tick(2);
		chk(levels, 30'h0, "rst lv");
		chk({oe_n, busy, irq}, 17'h0, "rst oe");
		step_chk(mrpc_pkg::CNT_SINGLE, mrpc_pkg::LVL_RESET, 4'hF);
		step_chk(mrpc_pkg::CNT_DUAL, mrpc_pkg::LVL_OFFSET, 4'hE);
		step_chk(mrpc_pkg::CNT_QUAD, mrpc_pkg::LVL_RESET, 4'hC);
		step_chk(mrpc_pkg::CNT_GLOBAL, mrpc_pkg::LVL_OFFSET, 4'h0);
		for (int k = 0; k < 24; k++) begin
			m = 2'($urandom);
			a = 4'($urandom);
			step_chk(m, lv_tab[$urandom % 3], a);
		end
		ctl.step(mrpc_pkg::CNT_GLOBAL, mrpc_pkg::LVL_INVALID, 4'h0);
		tick(8);
		chk({busy, irq}, 2'h1, "refuse");
		chk(levels, exp_lv, "kept");
		ctl.drop();
		ctl.xfer(mrpc_pkg::CMD_CLEAR_IRQ, rd);
		tick(6);
		chk(rd, 8'h05, "stat irq");
		chk({irq, sdo_oe_n}, 2'h1, "clear");
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		ctl.xfer(mrpc_pkg::CMD_FLOAT, rd);
		tick(6);
		chk(rd, 8'h04, "stat en");
		chk(oe_n, 15'h0, "frozen");
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		tick(6);
		chk(oe_n, 15'h7FFF, "all float");
		ctl.xfer(mrpc_pkg::CMD_ENABLE, rd);
		tick(6);
		chk(rd, 8'h00, "stat off");
		chk(oe_n, 15'h0, "enable");
		summarize();
	end
endmodule
